// >>> shared/bwpc_pkg.sv
// Package for the balancer watchdog and pause control block.
// Assumes a 25 MHz core clock and a serial command frame framed by chain select.
package bwpc_pkg;
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned TIMEOUT_MS      = 1500;
   localparam int unsigned TIMEOUT_CYCLES  = (CLK_HZ / 1000) * TIMEOUT_MS;
   localparam int unsigned WD_CNT_W        = 26;
   localparam logic [4:0]  ADDR_PATTERN    = 5'h15;
   localparam int unsigned CMD_BITS        = 8;
   localparam int unsigned NUM_BAL         = 6;
   localparam int unsigned BITCNT_W        = 4;
   localparam logic [1:0]  OP_WRITE        = 2'h0;
   localparam logic [1:0]  OP_READBACK     = 2'h1;
   localparam logic [1:0]  OP_STATUS       = 2'h2;
   localparam logic [1:0]  OP_EXECUTE      = 2'h3;
   localparam logic [1:0]  ACT_NONE        = 2'h0;

   typedef enum logic [2:0] {
      BWPC_IDLE    = 3'b001,
      BWPC_RUN     = 3'b010,
      BWPC_TIMEOUT = 3'b100
   } bwpc_state_t;

   // Command byte event from the shift logic
   typedef struct packed {
      logic       valid;
      logic       bad_parity;
      logic [1:0] op;
   } bwpc_cmd_t;

   // Per-balancer drive request, two bits per cell
   typedef struct packed {
      logic [2*NUM_BAL-1:0] act;
   } bwpc_bal_t;
endpackage

// >>> core/bwpc_cmd_rx.sv
// Command byte receiver: shifts in the first eight bits of each frame.
// Assumes serial clock and select are already synchronous to clock_i.
`timescale 1ns/1ns
module bwpc_cmd_rx (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             reset_i,
   // Serial frame
   input  wire logic             chain_select_in_i,
   input  wire logic             sclk_i,
   input  wire logic             sdi_i,
   // Decoded byte event
   output bwpc_pkg::bwpc_cmd_t   cmd_o
);
   typedef struct packed {
      logic                            sel_q;
      logic                            sck_q;
      logic                            done_q;
      logic [bwpc_pkg::BITCNT_W-1:0]   cnt_q;
      logic [bwpc_pkg::CMD_BITS-1:0]   sr_q;
      bwpc_pkg::bwpc_cmd_t             cmd_q;
   } bwpc_rx_t;

   bwpc_rx_t s_q, s_d;
   logic [bwpc_pkg::CMD_BITS-1:0] byte_v;

   always_comb begin
      s_d           = s_q;
      byte_v        = {s_q.sr_q[bwpc_pkg::CMD_BITS-2:0], sdi_i};
      s_d.sel_q     = chain_select_in_i;
      s_d.sck_q     = sclk_i;
      s_d.cmd_q     = '0;
      // Falling select edge opens a new frame
      if (s_q.sel_q && !chain_select_in_i) begin
         s_d.cnt_q  = '0;
         s_d.done_q = 1'b0;
      end
      // Only the first eight rising edges form the byte
      if (!chain_select_in_i && !s_q.done_q && sclk_i && !s_q.sck_q) begin
         s_d.sr_q  = byte_v;
         s_d.cnt_q = s_q.cnt_q + 4'h1;
         if (s_q.cnt_q == 4'h7) begin
            s_d.done_q           = 1'b1;
            // Byte counts even if the frame is then abandoned
            s_d.cmd_q.bad_parity = ^byte_v;
            s_d.cmd_q.valid      = (byte_v[7:3] == bwpc_pkg::ADDR_PATTERN) && !(^byte_v);
            s_d.cmd_q.op         = byte_v[2:1];
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s_q <= '{sel_q: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign cmd_o = s_q.cmd_q;
endmodule // bwpc_cmd_rx

// >>> core/bwpc_watchdog.sv
// Balancer watchdog, pause and single-transformer gating.
// Assumes command bytes and stored commands arrive synchronous to clock_i.
//
// Notes on behaviour
// - Watchdog count starts when a stored command begins executing.
// - Each valid eight-bit command byte clears the watchdog count.
// - Any valid op (execute, write, readback, status) restarts the watchdog.
// - Aborted frame still refreshes if eight bits with correct address and even parity arrived.
// - Status pin undriven after power-up and whenever neither balancing nor paused.
// - Status pin pulled low while balancing with communication alive.
// - Status pin released high after nominal 1.5 s without valid byte.
// - All balancers off while timed out; stored command kept.
// - After timeout only an execute restarts balancing; bytes just restart timer.
// - Watchdog disabled when secondary on-time clamp is defeated.
// - External high on pin pauses balancing; resumes same point on release.
// - Overvoltage trip via pin stops balancing, keeps command, resumes later.
// - Single-transformer mode turns all balancers off on execute of a command enabling more than one balancer.
// - Single-transformer mode routes the active balancer to first secondary path.
// - First eight bits after select falls form the command byte.
// - Byte addressed only when five leading bits equal 10101.
`timescale 1ns/1ns
module bwpc_watchdog #(
   parameter int unsigned TIMEOUT_CYC = bwpc_pkg::TIMEOUT_CYCLES
) (
   // Clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 reset_i,
   // Serial frame
   input  wire logic                 chain_select_in_i,
   input  wire logic                 sclk_i,
   input  wire logic                 sdi_i,
   // Stored command from the command holding logic
   input  bwpc_pkg::bwpc_bal_t       stored_cmd_i,
   input  wire logic                 stored_ok_i,
   // Configuration straps and pin level
   input  wire logic                 secondary_ontime_resistor_defeat_i,
   input  wire logic                 single_xfmr_i,
   input  wire logic                 watchdog_status_pin_i,
   // Pin drive
   output logic                      watchdog_status_pin_o,
   output logic                      watchdog_status_pin_oe_o,
   // Balancer drive
   output bwpc_pkg::bwpc_bal_t       bal_o,
   output logic                      secondary_gate_drive_first_en_o,
   output logic                      secondary_sense_first_en_o,
   output logic                      timed_out_o
);
   localparam logic [bwpc_pkg::WD_CNT_W-1:0] TERM = bwpc_pkg::WD_CNT_W'(TIMEOUT_CYC - 1);

   typedef struct packed {
      bwpc_pkg::bwpc_state_t               st_q;
      logic [bwpc_pkg::WD_CNT_W-1:0]       cnt_q;
      bwpc_pkg::bwpc_bal_t                 exec_q;
      bwpc_pkg::bwpc_bal_t                 bal_q;
      logic                                oe_q;
      logic                                g1_q;
      logic                                to_q;
   } bwpc_wd_t;

   bwpc_wd_t            s_q, s_d;
   bwpc_pkg::bwpc_cmd_t cmd;
   logic                ext_high;
   logic                allowed;

   function automatic logic [3:0] bwpc_count_on(input bwpc_pkg::bwpc_bal_t b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < bwpc_pkg::NUM_BAL; i++) begin
         if (b.act[2*i +: 2] != bwpc_pkg::ACT_NONE) n = n + 4'h1;
      end
      return n;
   endfunction

   bwpc_cmd_rx u_rx (
      .clock_i           (clock_i),
      .reset_i           (reset_i),
      .chain_select_in_i (chain_select_in_i),
      .sclk_i            (sclk_i),
      .sdi_i             (sdi_i),
      .cmd_o             (cmd)
   );

   always_comb begin
      s_d      = s_q;
      // Pin high while we pull low means external override or OVP trip
      ext_high = watchdog_status_pin_i && s_q.oe_q;
      allowed  = !single_xfmr_i || (bwpc_count_on(stored_cmd_i) <= 4'h1);
      // Bad parity terminates execution at once
      if (cmd.bad_parity) begin
         s_d.st_q   = bwpc_pkg::BWPC_IDLE;
         s_d.exec_q = '0;
      end else if (cmd.valid && cmd.op == bwpc_pkg::OP_EXECUTE) begin
         if (stored_ok_i && allowed) begin
            s_d.exec_q = stored_cmd_i;
         end else begin
            // Invalid or rejected command: execute turns all off
            s_d.exec_q = '0;
         end
         s_d.st_q  = bwpc_pkg::BWPC_RUN;
         s_d.cnt_q = '0;
      end else if (cmd.valid) begin
         s_d.cnt_q = '0;
      end else if (s_q.st_q == bwpc_pkg::BWPC_RUN && !secondary_ontime_resistor_defeat_i) begin
         // Counter holds while the watchdog is defeated
         if (s_q.cnt_q >= TERM) begin
            s_d.st_q = bwpc_pkg::BWPC_TIMEOUT;
         end else begin
            s_d.cnt_q = s_q.cnt_q + 26'h1;
         end
      end
      if (s_d.st_q == bwpc_pkg::BWPC_RUN && s_d.exec_q == '0) begin
         s_d.st_q = bwpc_pkg::BWPC_IDLE;
      end
      s_d.oe_q  = (s_q.st_q == bwpc_pkg::BWPC_RUN);
      s_d.to_q  = (s_q.st_q == bwpc_pkg::BWPC_TIMEOUT);
      // Pause keeps exec_q so balancing resumes where it left off
      if (s_q.st_q == bwpc_pkg::BWPC_RUN && !ext_high) begin
         s_d.bal_q = s_q.exec_q;
      end else begin
         s_d.bal_q = '0;
      end
      s_d.g1_q = single_xfmr_i && (s_d.bal_q != '0);
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s_q <= '{st_q: bwpc_pkg::BWPC_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign watchdog_status_pin_o           = 1'b0;
   assign watchdog_status_pin_oe_o        = s_q.oe_q;
   assign bal_o                           = s_q.bal_q;
   assign secondary_gate_drive_first_en_o = s_q.g1_q;
   assign secondary_sense_first_en_o      = s_q.g1_q;
   assign timed_out_o                     = s_q.to_q;

   chk_idle_undriven: assert property (@(posedge clock_i) disable iff (reset_i)
      (s_q.st_q != bwpc_pkg::BWPC_RUN) |=> !watchdog_status_pin_oe_o)
      else $error("status pin driven while not balancing");
   chk_run_pulls: assert property (@(posedge clock_i) disable iff (reset_i)
      (s_q.st_q == bwpc_pkg::BWPC_RUN) |=> watchdog_status_pin_oe_o)
      else $error("status pin not pulled low while balancing");
   chk_timeout_off: assert property (@(posedge clock_i) disable iff (reset_i)
      (s_q.st_q == bwpc_pkg::BWPC_TIMEOUT) |=> (bal_o == '0))
      else $error("balancer active after timeout");
   chk_timeout_keeps: assert property (@(posedge clock_i) disable iff (reset_i)
      (s_q.st_q == bwpc_pkg::BWPC_TIMEOUT && !cmd.valid && !cmd.bad_parity)
      |=> $stable(s_q.exec_q))
      else $error("stored command lost in timeout");
   chk_byte_clears: assert property (@(posedge clock_i) disable iff (reset_i)
      cmd.valid |=> (s_q.cnt_q == '0))
      else $error("valid byte did not clear count");
   chk_no_resume: assert property (@(posedge clock_i) disable iff (reset_i)
      (s_q.st_q == bwpc_pkg::BWPC_TIMEOUT && cmd.valid && cmd.op != bwpc_pkg::OP_EXECUTE
       && !cmd.bad_parity) |=> (s_q.st_q == bwpc_pkg::BWPC_TIMEOUT))
      else $error("balancing restarted without execute");
   chk_expire_time: assert property (@(posedge clock_i) disable iff (reset_i)
      (s_q.st_q == bwpc_pkg::BWPC_RUN && s_q.cnt_q >= TERM && !cmd.valid && !cmd.bad_parity
       && !secondary_ontime_resistor_defeat_i) |=> (s_q.st_q == bwpc_pkg::BWPC_TIMEOUT))
      else $error("timeout not taken at terminal count");
   chk_defeat_hold: assert property (@(posedge clock_i) disable iff (reset_i)
      (secondary_ontime_resistor_defeat_i && s_q.st_q == bwpc_pkg::BWPC_RUN && !cmd.valid
       && !cmd.bad_parity) |=> (s_q.st_q == bwpc_pkg::BWPC_RUN))
      else $error("timeout while watchdog defeated");
   chk_pause_stop: assert property (@(posedge clock_i) disable iff (reset_i)
      (ext_high) |=> (bal_o == '0))
      else $error("balancing not paused by pin");
   chk_single_one: assert property (@(posedge clock_i) disable iff (reset_i)
      single_xfmr_i && $past(single_xfmr_i) |-> (bwpc_count_on(bal_o) <= 4'h1))
      else $error("more than one balancer in single mode");
   cov_execute: cover property (@(posedge clock_i) disable iff (reset_i)
      s_q.st_q == bwpc_pkg::BWPC_RUN && bal_o != '0);
   cov_timeout: cover property (@(posedge clock_i) disable iff (reset_i)
      s_q.st_q == bwpc_pkg::BWPC_TIMEOUT);
   cov_pause: cover property (@(posedge clock_i) disable iff (reset_i)
      ext_high ##1 !ext_high);
   cov_reject: cover property (@(posedge clock_i) disable iff (reset_i)
      single_xfmr_i && cmd.valid && cmd.op == bwpc_pkg::OP_EXECUTE && !allowed);
endmodule // bwpc_watchdog

// >>> tb/bwpc_host_model.sv
// Host model: sends one serial command frame per start handshake.
// Assumes the bench raises start and waits for done to fall, then rise.
`timescale 1ns/1ns
module bwpc_host_model (
   // Clock
   input  wire logic       clock_i,
   // Frame request
   input  wire logic       start_i,
   input  wire logic [7:0] byte_i,
   input  wire logic [3:0] nbits_i,
   // Serial frame
   output logic            chain_select_in_o,
   output logic            sclk_o,
   output logic            sdi_o,
   output logic            done_o
);
   initial begin
      chain_select_in_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      done_o = 1'b1;
   end
   always begin : frame
      int i;
      @(negedge clock_i iff start_i);
      done_o = 1'b0;
      chain_select_in_o = 1'b0;
      repeat (2) @(negedge clock_i);
      // Bits past the eighth are filler, as an aborted long transfer would send
      for (i = 0; i < int'(nbits_i); i++) begin
         sdi_o = (i < 8) ? byte_i[7 - i] : i[0];
         repeat (2) @(negedge clock_i);
         sclk_o = 1'b1;
         repeat (2) @(negedge clock_i);
         sclk_o = 1'b0;
      end
      // Data no longer held once the frame ends
      sdi_o = ~sdi_o;
      chain_select_in_o = 1'b1;
      done_o = 1'b1;
   end
endmodule // bwpc_host_model

// >>> tb/test_balancer_watchdog_pause_control.sv
// Self-checking bench for the balancer watchdog and pause control.
// Assumes a shortened timeout and a pull-up on the status pin.
`timescale 1ns/1ns
module test_balancer_watchdog_pause_control;
   localparam int unsigned TO_CYC = 80;
   logic                clock = 1'b0;
   logic                reset = 1'b1;
   logic                start = 1'b0;
   logic                ext_hi = 1'b0;
   logic                defeat = 1'b0;
   logic                single = 1'b0;
   logic [7:0]          byte_v = 8'h00;
   logic [3:0]          nbits = 4'h8;
   bwpc_pkg::bwpc_bal_t stored = '{act: 12'h400};
   bwpc_pkg::bwpc_bal_t bal;
   logic                sel, sclk, sdi, done, pin, pin_o, oe, gfe, sfe, tout;
   int                  miscompares = 0;
   int                  num_checks = 0;
   int                  op;

   always #20 clock = ~clock;
   // Pull-up wins when undriven; an external high overrides the pull-down
   // Pin never tied low here, so timeout shutdown stays armed
   assign pin = ext_hi ? 1'b1 : (oe ? pin_o : 1'b1);

   bwpc_host_model bwpc_host_model_i (.clock_i(clock), .start_i(start), .byte_i(byte_v),
      .nbits_i(nbits), .chain_select_in_o(sel), .sclk_o(sclk), .sdi_o(sdi), .done_o(done));
   bwpc_watchdog #(.TIMEOUT_CYC(TO_CYC)) bwpc_watchdog_i (.clock_i(clock), .reset_i(reset),
      .chain_select_in_i(sel), .sclk_i(sclk), .sdi_i(sdi), .stored_cmd_i(stored),
      .stored_ok_i(1'b1), .secondary_ontime_resistor_defeat_i(defeat),
      .single_xfmr_i(single), .watchdog_status_pin_i(pin), .watchdog_status_pin_o(pin_o),
      .watchdog_status_pin_oe_o(oe), .bal_o(bal), .secondary_gate_drive_first_en_o(gfe),
      .secondary_sense_first_en_o(sfe), .timed_out_o(tout));

   task automatic final_report();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [11:0] got, input logic [11:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Command byte with the parity bit making the byte even
   function automatic logic [7:0] mk(input logic [1:0] code);
      return {bwpc_pkg::ADDR_PATTERN, code, ^{bwpc_pkg::ADDR_PATTERN, code}};
   endfunction

   task automatic send(input logic [7:0] b, input logic [3:0] n);
      int k;
      byte_v = b;
      nbits = n;
      start = 1'b1;
      for (k = 0; k < 400 && done !== 1'b0; k++) @(negedge clock);
      if (k == 400) begin
         miscompares++;
         final_report();
      end
      start = 1'b0;
      for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge clock);
      if (k == 400) begin
         miscompares++;
         final_report();
      end
      cyc(4);
   endtask

   task automatic expect_run(input logic [11:0] exp, input string what);
      chk_flag(oe, 1'b1, what);
      chk_vec(bal.act, exp, what);
      chk_flag(tout, 1'b0, what);
   endtask

   task automatic sc_refresh_then_timeout();
      send(mk(bwpc_pkg::OP_EXECUTE), 4'h8);
      expect_run(12'h400, "execute");
      chk_flag(gfe, 1'b0, "first path off");
      // Gaps kept well inside the shortened timeout
      cyc(20);
      for (op = 0; op < 3; op++) begin
         // Last one is an aborted long frame
         send(mk(op[1:0]), (op == 2) ? 4'hB : 4'h8);
         cyc(20);
      end
      expect_run(12'h400, "refreshed");
      chk_flag(pin, 1'b0, "pin low");
      send(8'h6F, 4'h8);
      cyc(50);
      chk_flag(tout, 1'b1, "timed out");
      chk_flag(oe, 1'b0, "pin released");
      chk_vec(bal.act, 12'h000, "all off");
      send(mk(bwpc_pkg::OP_STATUS), 4'h8);
      chk_vec(bal.act, 12'h000, "still off");
      chk_flag(tout, 1'b1, "still timed out");
      send(mk(bwpc_pkg::OP_EXECUTE), 4'h8);
      expect_run(12'h400, "kept command runs");
   endtask

   task automatic sc_pause();
      send(mk(bwpc_pkg::OP_EXECUTE), 4'h8);
      ext_hi = 1'b1;
      cyc(3);
      chk_vec(bal.act, 12'h000, "paused");
      chk_flag(tout, 1'b0, "pause not timeout");
      ext_hi = 1'b0;
      cyc(3);
      chk_vec(bal.act, 12'h400, "resumed");
   endtask

   task automatic sc_defeat();
      defeat = 1'b1;
      send(mk(bwpc_pkg::OP_EXECUTE), 4'h8);
      cyc(3 * TO_CYC);
      expect_run(12'h400, "defeated watchdog");
      defeat = 1'b0;
   endtask

   task automatic sc_single();
      single = 1'b1;
      stored.act = 12'h500;
      send(mk(bwpc_pkg::OP_EXECUTE), 4'h8);
      chk_vec(bal.act, 12'h000, "two balancers refused");
      stored.act = 12'h0C0;
      send(mk(bwpc_pkg::OP_EXECUTE), 4'h8);
      chk_vec(bal.act, 12'h0C0, "one balancer");
      chk_flag(gfe, 1'b1, "first gate");
      chk_flag(sfe, 1'b1, "first sense");
      // Odd parity byte ends balancing at once
      send(mk(bwpc_pkg::OP_EXECUTE) ^ 8'h01, 4'h8);
      chk_vec(bal.act, 12'h000, "bad parity stops");
      chk_flag(oe, 1'b0, "bad parity releases pin");
   endtask

   initial begin
      cyc(5);
      reset = 1'b0;
      cyc(2);
      chk_flag(oe, 1'b0, "undriven after reset");
      sc_refresh_then_timeout();
      sc_pause();
      sc_defeat();
      sc_single();
      final_report();
   end
endmodule // test_balancer_watchdog_pause_control
